// *** inc/rsw_pkg.sv ***
// constants and types for the reset sequencer with window watchdog.
// assumes one 100 MHz clock that also stands for the divided oscillator.
// Behaviour
// RQ1 - three reset sources: external pin, low-voltage detect, watchdog
// RQ2 - each reset runs active phase, stabilisation delay, then vector fetch
// RQ3 - delay lasts 256 or 4096 cycles, chosen by option input
// RQ4 - reset pin driven low for the whole delay phase
// RQ5 - reset vector fetched from addresses fffe and ffff
// RQ6 - vector fetch lasts exactly two cycles before running
// RQ7 - reset pin is an input and an open-drain output
// RQ8 - low level on reset pin is caught without the clock
// RQ9 - outside logic keeps reset pin low on a blank part
// RQ10 - activation bit set only by software, cleared only by reset
// RQ11 - hardware watchdog option makes watchdog run regardless
// RQ12 - 7-bit counter decrements once every 16384 divided clock cycles
// RQ13 - enabled watchdog resets when counter rolls from 40h to 3fh
// RQ14 - window register holds 7-bit window, top bit reserved
// RQ15 - both watchdog registers reset to 7fh, watchdog disabled
// RQ16 - counter write while counter above window triggers watchdog reset
// RQ17 - watchdog request runs the same three reset phases
package rsw_pkg;
	// register map, byte offsets on the plain register port
	localparam logic [7:0]  ADDR_CTRL   = 8'h00;
	localparam logic [7:0]  ADDR_WIN    = 8'h01;
	localparam logic [7:0]  ADDR_CAUSE  = 8'h02;
	// field layout and reset values
	localparam int          ACT_BIT     = 7;
	localparam int          CNT_MSB     = 6;
	localparam logic [6:0]  CNT_RST     = 7'h7f;
	localparam logic [6:0]  WIN_RST     = 7'h7f;
	localparam logic [6:0]  ROLL_VAL    = 7'h40;
	// timing counts in clock cycles
	localparam logic [12:0] DLY_SHORT   = 13'h0100;
	localparam logic [12:0] DLY_LONG    = 13'h1000;
	localparam int          WDG_TICK    = 16384;
	localparam int          PRESC_W     = 15;
	localparam logic [4:0]  ACT_POR_CYC = 5'h04;
	localparam logic [4:0]  ACT_WDG_CYC = 5'h10;
	localparam logic [2:0]  GUARD_CYC   = 3'h4;
	// reset vector
	localparam logic [15:0] VEC_LO      = 16'hfffe;
	localparam logic [15:0] VEC_HI      = 16'hffff;

	typedef enum logic [1:0] {S_ACTIVE, S_DELAY, S_FETCH, S_RUN} rsw_state_t;
	typedef enum logic [1:0] {SRC_POR, SRC_EXT, SRC_LVD, SRC_WDG} rsw_src_t;
endpackage : rsw_pkg

// *** rtl/rsw_top.sv ***
// reset sequencer: three sources, delay phase, vector fetch, window watchdog.
// assumes the pin wire is resolved outside from RESET_PIN_OE with a pull-up.
`timescale 1ns/1ps
module rsw_top #(
	parameter int WDG_TICK_CYC = rsw_pkg::WDG_TICK
) (
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic [7:0]  ADDR,
	input  wire logic [7:0]  WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic      [7:0]  RDATA,
	input  wire logic        RESET_PIN_IN,
	output logic             RESET_PIN_OUT,
	output logic             RESET_PIN_OE,
	input  wire logic        LVD_IN,
	input  wire logic        OPT_LONG_DELAY,
	input  wire logic        OPT_HW_WDG,
	output logic             CPU_RESET,
	output logic             VECTOR_FETCH,
	output logic      [15:0] VECTOR_ADDR
);
	typedef struct packed {
		rsw_pkg::rsw_state_t        st;
		rsw_pkg::rsw_src_t          src;
		logic [4:0]                 acnt;
		logic [12:0]                dcnt;
		logic                       fcnt;
		logic [2:0]                 guard;
		logic                       pin_s1;
		logic                       pin_s2;
		logic                       lvd_s1;
		logic                       lvd_s2;
		logic                       optl_s1;
		logic                       optl_s2;
		logic                       opth_s1;
		logic                       opth_s2;
		logic                       act;
		logic [6:0]                 cnt;
		logic [6:0]                 win;
		logic [rsw_pkg::PRESC_W-1:0] presc;
		logic [7:0]                 rdata;
		logic                       cpu_rst;
		logic                       oe;
		logic                       vfetch;
		logic [15:0]                vaddr;
		logic [2:0]                 cause;
	} rsw_state_reg_t;

	localparam logic [rsw_pkg::PRESC_W-1:0] PRESC_LOAD =
		rsw_pkg::PRESC_W'(WDG_TICK_CYC - 1);

	rsw_state_reg_t s_reg;
	rsw_state_reg_t s_next;
	logic           pin_low_cap;
	logic           tick;
	logic           wdg_en;
	logic           wr_ctrl;
	logic           premature;
	logic           roll;
	logic           wdg_req;

	// RQ8 async capture
	// latches a low pin even with the clock stopped; cleared once pin is high
	always_ff @(posedge CLK or negedge RESET_PIN_IN) begin
		if (!RESET_PIN_IN)
			pin_low_cap <= 1'b1;
		else
			pin_low_cap <= 1'b0;
	end

	// watchdog request terms
	assign tick    = (s_reg.presc == '0);
	// RQ11 hardware option overrides
	assign wdg_en  = s_reg.act | s_reg.opth_s2;
	assign wr_ctrl = WR && (ADDR == rsw_pkg::ADDR_CTRL);
	// RQ16 premature refresh
	assign premature = wdg_en && wr_ctrl && (s_reg.cnt > s_reg.win);
	// RQ13 rollover 40h to 3fh
	assign roll = wdg_en && tick && (s_reg.cnt == rsw_pkg::ROLL_VAL);
	// a write clearing the counter msb is treated like the rollover
	assign wdg_req = !s_reg.cpu_rst && (roll || premature ||
		(wr_ctrl && wdg_en && !WDATA[rsw_pkg::CNT_MSB]));

	// next-state logic for sequencer, watchdog and register port
	always_comb begin
		s_next       = s_reg;
		s_next.rdata = 8'h00;
		// two-flop synchronisers for pin, detector and option inputs
		s_next.pin_s1  = pin_low_cap;
		s_next.pin_s2  = s_reg.pin_s1;
		s_next.lvd_s1  = LVD_IN;
		s_next.lvd_s2  = s_reg.lvd_s1;
		s_next.optl_s1 = OPT_LONG_DELAY;
		s_next.optl_s2 = s_reg.optl_s1;
		s_next.opth_s1 = OPT_HW_WDG;
		s_next.opth_s2 = s_reg.opth_s1;

		// RQ15 watchdog reset values
		// the whole watchdog stays at reset while the cpu is held in reset
		if (s_reg.cpu_rst) begin
			s_next.act   = 1'b0;
			s_next.cnt   = rsw_pkg::CNT_RST;
			s_next.win   = rsw_pkg::WIN_RST;
			s_next.presc = PRESC_LOAD;
		end else begin
			// RQ12 prescaled decrement
			s_next.presc = tick ? PRESC_LOAD : s_reg.presc - 1'b1;
			if (wr_ctrl) begin
				// RQ10 set-only activation
				s_next.act = s_reg.act | WDATA[rsw_pkg::ACT_BIT];
				s_next.cnt = WDATA[6:0];
			end else if (tick) begin
				s_next.cnt = s_reg.cnt - 7'h01;
			end
			// RQ14 window value
			if (WR && (ADDR == rsw_pkg::ADDR_WIN))
				s_next.win = WDATA[6:0];
		end

		// register read, answer stands only in the following cycle
		if (RD) begin
			unique case (ADDR)
				rsw_pkg::ADDR_CTRL:  s_next.rdata = {s_reg.act, s_reg.cnt};
				rsw_pkg::ADDR_WIN:   s_next.rdata = {1'b0, s_reg.win};
				rsw_pkg::ADDR_CAUSE: s_next.rdata = {5'h00, s_reg.cause};
				default:             s_next.rdata = 8'h00;
			endcase
		end

		// RQ2 phase order
		unique case (s_reg.st)
			rsw_pkg::S_ACTIVE: begin
				// end of the source-dependent active phase
				if ((s_reg.src == rsw_pkg::SRC_EXT && !s_reg.pin_s2) ||
				    (s_reg.src == rsw_pkg::SRC_LVD && !s_reg.lvd_s2) ||
				    ((s_reg.src == rsw_pkg::SRC_POR ||
				      s_reg.src == rsw_pkg::SRC_WDG) &&
				     s_reg.acnt == 5'h00)) begin
					// RQ3 option-selected delay
					s_next.st   = rsw_pkg::S_DELAY;
					s_next.dcnt = s_reg.optl_s2 ?
						rsw_pkg::DLY_LONG - 13'h0001 :
						rsw_pkg::DLY_SHORT - 13'h0001;
				end else if (s_reg.acnt != 5'h00) begin
					s_next.acnt = s_reg.acnt - 5'h01;
				end
			end
			rsw_pkg::S_DELAY: begin
				if (s_reg.dcnt == 13'h0000) begin
					s_next.st   = rsw_pkg::S_FETCH;
					s_next.fcnt = 1'b0;
				end else begin
					s_next.dcnt = s_reg.dcnt - 13'h0001;
				end
			end
			rsw_pkg::S_FETCH: begin
				// RQ6 two fetch cycles
				if (s_reg.fcnt) begin
					s_next.st    = rsw_pkg::S_RUN;
					s_next.guard = rsw_pkg::GUARD_CYC;
				end else begin
					s_next.fcnt = 1'b1;
				end
			end
			rsw_pkg::S_RUN: begin
				// guard hides our own released drive still in the sync
				if (s_reg.guard != 3'h0)
					s_next.guard = s_reg.guard - 3'h1;
			end
		endcase

		// RQ1 source entry
		// low voltage wins, then the pin, then the watchdog
		if (s_reg.lvd_s2 && !(s_reg.st == rsw_pkg::S_ACTIVE &&
		                      s_reg.src == rsw_pkg::SRC_LVD)) begin
			s_next.st    = rsw_pkg::S_ACTIVE;
			s_next.src   = rsw_pkg::SRC_LVD;
			s_next.cause = 3'h2;
		end else if (s_reg.st == rsw_pkg::S_RUN && s_reg.guard == 3'h0 &&
		             s_reg.pin_s2) begin
			s_next.st    = rsw_pkg::S_ACTIVE;
			s_next.src   = rsw_pkg::SRC_EXT;
			s_next.cause = 3'h1;
		end else if (wdg_req) begin
			// RQ17 watchdog as a source
			s_next.st    = rsw_pkg::S_ACTIVE;
			s_next.src   = rsw_pkg::SRC_WDG;
			s_next.acnt  = rsw_pkg::ACT_WDG_CYC - 5'h01;
			s_next.cause = 3'h4;
		end

		// outputs follow the next state so they leave flops directly
		s_next.cpu_rst = (s_next.st != rsw_pkg::S_RUN);
		// RQ4 pin low in delay
		s_next.oe      = (s_next.st == rsw_pkg::S_DELAY);
		s_next.vfetch  = (s_next.st == rsw_pkg::S_FETCH);
		// RQ5 fixed vector location
		s_next.vaddr   = !s_next.vfetch ? 16'h0000 :
			(s_next.fcnt ? rsw_pkg::VEC_HI : rsw_pkg::VEC_LO);
	end

	// state register, power-up runs a short active phase first
	always_ff @(posedge CLK) begin
		if (RST) begin
			s_reg         <= '0;
			s_reg.st      <= rsw_pkg::S_ACTIVE;
			s_reg.src     <= rsw_pkg::SRC_POR;
			s_reg.acnt    <= rsw_pkg::ACT_POR_CYC - 5'h01;
			s_reg.cnt     <= rsw_pkg::CNT_RST;
			s_reg.win     <= rsw_pkg::WIN_RST;
			s_reg.presc   <= PRESC_LOAD;
			s_reg.cpu_rst <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	// RQ7 open-drain: only ever drives low
	assign RESET_PIN_OUT = 1'b0;
	assign RESET_PIN_OE  = s_reg.oe;
	assign RDATA         = s_reg.rdata;
	assign CPU_RESET     = s_reg.cpu_rst;
	assign VECTOR_FETCH  = s_reg.vfetch;
	assign VECTOR_ADDR   = s_reg.vaddr;

	// helper: length of the current pin drive
	logic [12:0] oe_len;
	always_ff @(posedge CLK) begin
		if (RST || !s_reg.oe)
			oe_len <= 13'h0000;
		else
			oe_len <= oe_len + 13'h0001;
	end

	property p_delay_len;
		@(posedge CLK) disable iff (RST)
		$fell(RESET_PIN_OE) |->
			($past(oe_len) == 13'h00ff || $past(oe_len) == 13'h0fff);
	endproperty
	a_delay_len: assert property (p_delay_len) // RQ3
		else $error("delay phase length is not 256 or 4096");

	property p_fetch_two;
		@(posedge CLK) disable iff (RST)
		$fell(RESET_PIN_OE) |->
			VECTOR_FETCH ##1 VECTOR_FETCH ##1 (!VECTOR_FETCH && !CPU_RESET);
	endproperty
	a_fetch_two: assert property (p_fetch_two) // RQ6
		else $error("vector fetch not exactly two cycles after delay");

	property p_vector;
		@(posedge CLK) disable iff (RST)
		$rose(VECTOR_FETCH) |->
			(VECTOR_ADDR == 16'hfffe) ##1 (VECTOR_ADDR == 16'hffff);
	endproperty
	a_vector: assert property (p_vector) // RQ5
		else $error("vector fetch addresses wrong");

	property p_order;
		@(posedge CLK) disable iff (RST)
		$rose(RESET_PIN_OE) |->
			CPU_RESET && $past(s_reg.st) == rsw_pkg::S_ACTIVE;
	endproperty
	a_order: assert property (p_order) // RQ2
		else $error("delay phase not preceded by active phase");

	property p_pin_hold;
		@(posedge CLK) disable iff (RST)
		$rose(RESET_PIN_OE) |-> RESET_PIN_OE [*8];
	endproperty
	a_pin_hold: assert property (p_pin_hold) // RQ4
		else $error("reset pin released early in delay phase");

	property p_roll;
		@(posedge CLK) disable iff (RST)
		(!CPU_RESET && s_reg.act && tick && s_reg.cnt == 7'h40 &&
		 !s_reg.lvd_s2 && !s_reg.pin_s2) |=>
			CPU_RESET && s_reg.src == rsw_pkg::SRC_WDG;
	endproperty
	a_roll: assert property (p_roll) // RQ13
		else $error("no watchdog reset at rollover");

	property p_hw_wdg;
		@(posedge CLK) disable iff (RST)
		(!CPU_RESET && s_reg.opth_s2 && !s_reg.act && tick &&
		 s_reg.cnt == 7'h40) |=> CPU_RESET;
	endproperty
	a_hw_wdg: assert property (p_hw_wdg) // RQ11
		else $error("hardware watchdog option did not force reset");

	property p_premature;
		@(posedge CLK) disable iff (RST)
		(!CPU_RESET && s_reg.act && WR && ADDR == 8'h00 &&
		 s_reg.cnt > s_reg.win) |=> CPU_RESET ##1 CPU_RESET;
	endproperty
	a_premature: assert property (p_premature) // RQ16
		else $error("premature counter write did not reset");

	property p_act_sticky;
		@(posedge CLK) disable iff (RST)
		(s_reg.act && !CPU_RESET) |=> s_reg.act;
	endproperty
	a_act_sticky: assert property (p_act_sticky) // RQ10
		else $error("activation bit cleared without reset");

	property p_wdg_rst;
		@(posedge CLK) disable iff (RST)
		$rose(CPU_RESET) |=>
			(s_reg.cnt == 7'h7f && s_reg.win == 7'h7f && !s_reg.act);
	endproperty
	a_wdg_rst: assert property (p_wdg_rst) // RQ15
		else $error("watchdog registers not at 7fh in reset");

	property p_tick_only;
		@(posedge CLK) disable iff (RST)
		(!CPU_RESET && !tick && !WR) |=> $stable(s_reg.cnt);
	endproperty
	a_tick_only: assert property (p_tick_only) // RQ12
		else $error("counter moved without a prescaler tick");

	property p_ext;
		@(posedge CLK) disable iff (RST)
		(s_reg.st == rsw_pkg::S_RUN && s_reg.guard == 3'h0 &&
		 s_reg.pin_s2) |=>
			CPU_RESET && s_reg.src != rsw_pkg::SRC_WDG;
	endproperty
	a_ext: assert property (p_ext) // RQ1
		else $error("external pin low did not enter reset");
endmodule : rsw_top

// *** test/rsw_ext_rst_model.sv ***
// external reset circuitry model sharing the open-drain reset pin.
// assumes a weak pull-up on the wire and a bench that asks for pulses.
`timescale 1ns/1ps
module rsw_ext_rst_model (
	input  wire logic       clk,
	input  wire logic       pull_go,
	input  wire logic [7:0] pull_len,
	input  wire logic       dev_oe,
	input  wire logic       dev_out,
	output logic            pin
);
	logic [7:0] left_reg = 8'h00;

	// hold pin low
	// one low pulse per request, length in clock cycles
	always_ff @(posedge clk) begin
		if (pull_go)
			left_reg <= pull_len;
		else if (left_reg != 8'h00)
			left_reg <= left_reg - 8'h01;
	end

	// shared open drain
	// either party pulls low; the pull-up wins otherwise
	assign pin = ~((dev_oe & ~dev_out) | (left_reg != 8'h00));
endmodule : rsw_ext_rst_model

// *** test/rsw_tb.sv ***
// self-checking bench for the reset sequencer with window watchdog.
// assumes a short watchdog tick of 8 cycles and the pin model beside it.
`timescale 1ns/1ps
`define CHK(g, e) begin \
	checks_done++; \
	if ((g) !== (e)) begin \
		mismatches++; \
		$display("[FAIL] %0t got %h exp %h", $time, g, e); \
	end \
end
module testbench;
	logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
	logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, pull_len = 8'h00;
	logic        pin, oe, out, cpu_rst, vfetch, rd_d = 1'b0, vf_d = 1'b0;
	logic        low_voltage_detect = 1'b0, opt_long = 1'b0, opt_hw = 1'b0, pull_go = 1'b0;
	logic [15:0] vaddr, e16;
	logic [7:0]  e8, m8, q_rd[$], q_msk[$];
	logic [15:0] q_vec[$];
	int          q_dly[$], d, oe_cnt = 0, cyc = 0;
	int          mismatches = 0, checks_done = 0;

	rsw_top #(.WDG_TICK_CYC(8)) dut (.CLK(clk), .RST(rst), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.RESET_PIN_IN(pin), .RESET_PIN_OUT(out), .RESET_PIN_OE(oe),
		.LVD_IN(low_voltage_detect), .OPT_LONG_DELAY(opt_long), .OPT_HW_WDG(opt_hw),
		.CPU_RESET(cpu_rst), .VECTOR_FETCH(vfetch), .VECTOR_ADDR(vaddr));
	rsw_ext_rst_model ext (.clk(clk), .pull_go(pull_go), .pull_len(pull_len),
		.dev_oe(oe), .dev_out(out), .pin(pin));

	// free-running clock, 10 ns period
	initial begin
		forever #5 clk = ~clk;
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop

	// a gap cycle after each register strobe keeps drivers race free
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e,
		input logic [7:0] m);
		q_rd.push_back(e);
		q_msk.push_back(m);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
	endtask : rd_reg

	task automatic expect_seq(input int dly);
		q_dly.push_back(dly);
		q_vec.push_back(16'hfffe);
		q_vec.push_back(16'hffff);
	endtask : expect_seq

	task automatic pulse_pin(input logic [7:0] len);
		pull_len <= len;
		pull_go <= 1'b1;
		@(posedge clk);
		pull_go <= 1'b0;
	endtask : pulse_pin

	// bounded wait for reset entry then release; n is cycles to entry
	task automatic wait_run(output int n);
		int k;
		n = 0;
		while (cpu_rst !== 1'b1 && n < 2000) begin
			@(negedge clk);
			n++;
		end
		k = 0;
		while (cpu_rst !== 1'b0 && k < 6000) begin
			@(negedge clk);
			k++;
		end
		`CHK(cpu_rst, 1'b0)
		repeat (6) @(posedge clk);
	endtask : wait_run

	// watcher: pops the oldest note whenever a result shows
	always @(posedge clk) begin
		rd_d <= rd;
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			report_and_stop();
		end
	end
	always @(negedge clk) begin
		if (rd_d) begin
			e8 = (q_rd.size() != 0) ? q_rd.pop_front() : 8'hxx;
			m8 = (q_msk.size() != 0) ? q_msk.pop_front() : 8'hff;
			`CHK(rdata & m8, e8)
		end
		if (vfetch) begin
			e16 = (q_vec.size() != 0) ? q_vec.pop_front() : 16'h0000;
			`CHK(vaddr, e16)
		end
		if (vf_d && !vfetch)
			`CHK(cpu_rst, 1'b0)
		vf_d = vfetch;
		if (oe) begin
			oe_cnt++;
			`CHK({cpu_rst, out, pin}, 3'b100)
		end else if (oe_cnt != 0) begin
			d = (q_dly.size() != 0) ? q_dly.pop_front() : -1;
			`CHK(oe_cnt, d)
			`CHK(vfetch, 1'b1)
			oe_cnt = 0;
		end
	end

	// main sequence
	initial begin
		int n;
		logic [7:0] r;
		void'($urandom(12883));
		repeat (5) @(posedge clk);
		expect_seq(256);
		rst <= 1'b0;
		wait_run(n);
		rd_reg(8'h00, 8'h7f, 8'hff);
		rd_reg(8'h01, 8'h7f, 8'hff);
		rd_reg(8'h03, 8'h00, 8'hff);
		r = $urandom;
		wr_reg(8'h01, r);
		rd_reg(8'h01, {1'b0, r[6:0]}, 8'hff);
		wr_reg(8'h01, 8'h7f);
		// act set by software, a zero write leaves it set
		wr_reg(8'h00, 8'hff);
		wr_reg(8'h00, 8'h7f);
		rd_reg(8'h00, 8'h80, 8'h80);
		expect_seq(256);
		wait_run(n);
		`CHK(n >= 480 && n <= 520, 1'b1)
		rd_reg(8'h02, 8'h04, 8'hff);
		rd_reg(8'h00, 8'h00, 8'h80);
		// early service write with the counter above the window
		wr_reg(8'h01, 8'($urandom_range(8'h3e, 0)));
		wr_reg(8'h00, 8'hff);
		expect_seq(256);
		wr_reg(8'h00, 8'hff);
		wait_run(n);
		`CHK(n < 5, 1'b1)
		rd_reg(8'h02, 8'h04, 8'hff);
		opt_hw <= 1'b1;
		expect_seq(256);
		wait_run(n);
		opt_hw <= 1'b0;
		rd_reg(8'h02, 8'h04, 8'hff);
		opt_long <= 1'b1;
		expect_seq(4096);
		pulse_pin(8'h14);
		wait_run(n);
		rd_reg(8'h02, 8'h01, 8'hff);
		opt_long <= 1'b0;
		// a pin pulse inside the delay must not restart it
		low_voltage_detect <= 1'b1;
		expect_seq(256);
		repeat (10) @(posedge clk);
		low_voltage_detect <= 1'b0;
		repeat (20) @(posedge clk);
		pulse_pin(8'h0a);
		wait_run(n);
		rd_reg(8'h02, 8'h02, 8'hff);
		// clearing the counter msb by a write acts as the rollover
		wr_reg(8'h00, 8'hff);
		expect_seq(256);
		wr_reg(8'h00, 8'hbf);
		wait_run(n);
		`CHK(n < 5, 1'b1)
		rd_reg(8'h02, 8'h04, 8'hff);
		`CHK(q_dly.size() + q_vec.size() + q_rd.size(), 0)
		report_and_stop();
	end
endmodule : testbench
